// File: hw/bil_pkg.sv
// package of constants and types for the boot image loader
// assumes a single core clock domain (mclk) and a synchronous reset
package bil_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_PHASE_US = 15;
  localparam int RESET_PHASE_CYCLES = (RESET_PHASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_DIV = 8;
  localparam int SCLK_HALF = SCLK_DIV / 2;
  localparam int SPI1_DIV = 160;
  localparam int SPI1_HALF = SPI1_DIV / 2;

  // ----------------------------------------------------------------
  // image format and crc
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;
  localparam logic [31:0] CRC_BYPASS = 32'h0d15ab1e;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000;
  localparam logic [15:0] OTP_START_ADDR = 16'h0000;
  localparam logic [15:0] RAM_BASE_ADDR = 16'h0000;
  localparam int SECURE_BOOT_BIT = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  // ----------------------------------------------------------------
  // boot sources and loader states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIL_SRC_QSPI,
    BIL_SRC_SPI,
    BIL_SRC_SLAVE,
    BIL_SRC_CHAN,
    BIL_SRC_OTP
  } bil_src_t;

  typedef enum logic [3:0] {
    BIL_ST_RESET,
    BIL_ST_SELECT,
    BIL_ST_CMD,
    BIL_ST_DATA,
    BIL_ST_WAIT,
    BIL_ST_RUN,
    BIL_ST_ERROR,
    BIL_ST_EXTERN
  } bil_state_t;

  typedef enum logic [1:0] {
    BIL_PH_LEN,
    BIL_PH_PROG,
    BIL_PH_CRC,
    BIL_PH_DONE
  } bil_phase_t;

  // crc-32 reflected, one byte
  function automatic logic [31:0] bil_crc_byte(input logic [31:0] crc, input logic [7:0] b);
    logic [31:0] c;
    c = crc ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : bil_crc_byte

endpackage : bil_pkg

// File: hw/bil_fifo.sv
// small synchronous fifo between byte assembly and the image parser
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
`default_nettype none
module bil_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign push = clk_en && in_valid && in_ready;
  assign pop = clk_en && out_valid && out_ready;

  // storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : bil_fifo
`default_nettype wire

// File: hw/bil_loader.sv
// boot sequencer: reset phase, boot source select, flash/otp image load
// assumes straps and flash data come from pins, ram/otp are same clock
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: while chip reset is low stay idle and pull down all pins.
// RULE2: after reset release run an internal reset phase before booting.
// RULE3: secure-boot bit five set forces boot from one-time memory.
// RULE4: strap two low decodes straps one/zero to a tile boot source.
// RULE5: strap two high boots from channel end zero, straps pick links.
// RULE6: image is length word, four times length bytes, then crc word.
// RULE7: length and crc words are assembled least significant byte first.
// RULE8: program goes into ram from lowest address, runs from there.
// RULE9: crc covers length word and program bytes, not the crc word.
// RULE10: reflected crc-32, preset all ones, remainder inverted.
// RULE11: quad boot enables six pins and drives the serial clock.
// RULE12: quad boot sends read command and 24-bit zero address first.
// RULE13: clock idles low, data sampled on the rising edge.
// RULE14: each byte arrives as two nibbles, low nibble first.
// RULE15: fixed select, four data and one clock pin.
// RULE16: pin assignment hard wired, not changeable.
// RULE17: one-time-memory boot reads from its address zero.
// RULE18: single-bit spi boot, slower clock, bytes lsb first.
// RULE19: quad clock is core clock divided by eight.
// RULE20: crc mismatch without bypass raises error, program not started.
module bil_loader
  import bil_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic rst_n_pin,
  input wire logic [2:0] boot_strap_pins,
  input wire logic [31:0] security_reg,
  output logic pin_pulldown_en,
  output logic flash_select_pin,
  output logic serial_clock_pin,
  output logic [3:0] quad_data_out,
  output logic [3:0] quad_data_oe,
  input wire logic [3:0] quad_data_in,
  output logic [15:0] otp_addr,
  output logic otp_rd,
  input wire logic [7:0] otp_data,
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic [2:0] tile0_source,
  output logic [2:0] tile1_source,
  output logic [7:0] links_enabled,
  output logic links_five_wire,
  output logic run_start,
  output logic [15:0] run_addr,
  output logic boot_done,
  output logic boot_error
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstn_sync_reg;
  logic [2:0] strap_s1_reg, strap_s2_reg;
  logic [3:0] qd_s1_reg, qd_s2_reg;
  // two flops for every pin input
  always_ff @(posedge mclk) begin
    if (reset) begin
      rstn_sync_reg <= 2'h0;
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
      qd_s1_reg <= 4'h0;
      qd_s2_reg <= 4'h0;
    end else if (clk_en) begin
      rstn_sync_reg <= {rstn_sync_reg[0], rst_n_pin};
      strap_s1_reg <= boot_strap_pins;
      strap_s2_reg <= strap_s1_reg;
      qd_s1_reg <= quad_data_in;
      qd_s2_reg <= qd_s1_reg;
    end
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bil_state_t state_reg;
  bil_phase_t phase_reg;
  bil_src_t src_reg;
  logic [15:0] rst_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [5:0] bit_cnt_reg;
  logic sclk_reg;
  logic [31:0] shift_reg;
  logic [3:0] low_nib_reg;
  logic nib_half_reg;
  logic [31:0] len_reg, crc_word_reg, crc_reg, prog_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [15:0] wr_addr_reg;
  logic otp_pend_reg;
  logic chip_held;
  logic rise, fall, div_wrap;
  logic [7:0] half_cnt;
  logic byte_valid;
  logic [7:0] byte_data;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [31:0] crc_next;
  // RULE1: pulldowns during reset
  assign chip_held = !rstn_sync_reg[1];
  assign pin_pulldown_en = chip_held;
  // RULE19: divide by eight, spi slower
  assign half_cnt = (src_reg == BIL_SRC_SPI) ? 8'(SPI1_HALF) : 8'(SCLK_HALF);
  assign div_wrap = (div_cnt_reg == half_cnt - 8'h01);
  // RULE13: sample on rising, shift on falling; fifo full stalls clock
  assign rise = div_wrap && !sclk_reg && fifo_in_ready;
  assign fall = div_wrap && sclk_reg;
  // reset phase counter and top-level sequencing
  always_ff @(posedge mclk) begin
    if (reset || (clk_en && chip_held)) begin
      state_reg <= BIL_ST_RESET;
      rst_cnt_reg <= 16'h0000;
      src_reg <= BIL_SRC_QSPI;
      tile0_source <= 3'h0;
      tile1_source <= 3'h0;
      links_enabled <= 8'h00;
      links_five_wire <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        // RULE2: internal reset phase
        BIL_ST_RESET: begin
          rst_cnt_reg <= rst_cnt_reg + 16'h0001;
          if (rst_cnt_reg == 16'(RESET_PHASE_CYCLES - 1)) begin
            state_reg <= BIL_ST_SELECT;
          end
        end
        BIL_ST_SELECT: begin
          links_enabled <= 8'h00;
          links_five_wire <= 1'b0;
          tile1_source <= 3'(BIL_SRC_CHAN);
          // RULE3: secure boot override
          if (security_reg[SECURE_BOOT_BIT]) begin
            src_reg <= BIL_SRC_OTP;
            tile0_source <= 3'(BIL_SRC_OTP);
            state_reg <= BIL_ST_DATA;
          end else if (!strap_s2_reg[2]) begin
            // RULE4: strap decode, no links; only 11 moves tile 1 off
            state_reg <= strap_s2_reg[1] ? BIL_ST_EXTERN : BIL_ST_CMD;
            case (strap_s2_reg[1:0])
              2'h0: src_reg <= BIL_SRC_QSPI;
              2'h1: src_reg <= BIL_SRC_SPI;
              default: src_reg <= BIL_SRC_SLAVE;
            endcase
            if (strap_s2_reg[1:0] == 2'h3) begin
              tile1_source <= 3'(BIL_SRC_SLAVE);
            end
            tile0_source <= (strap_s2_reg[1:0] == 2'h0) ? 3'(BIL_SRC_QSPI) :
                            (strap_s2_reg[1:0] == 2'h1) ? 3'(BIL_SRC_SPI) : 3'(BIL_SRC_SLAVE);
          end else begin
            // RULE5: channel boot, links by strap, only strap 00 (link zero alone) is 2-wire
            src_reg <= BIL_SRC_CHAN;
            tile0_source <= 3'(BIL_SRC_CHAN);
            state_reg <= BIL_ST_EXTERN;
            links_five_wire <= (strap_s2_reg[1:0] != 2'h0);
            case (strap_s2_reg[1:0])
              2'h0: links_enabled <= 8'h01;
              2'h1: links_enabled <= 8'hf0;
              2'h2: links_enabled <= 8'h66;
              default: links_enabled <= 8'h0f;
            endcase
          end
        end
        BIL_ST_CMD: begin
          if (fall && bit_cnt_reg == 6'd31) begin
            state_reg <= BIL_ST_DATA;
          end
        end
        BIL_ST_DATA: begin
          if (phase_reg == BIL_PH_DONE && !sclk_reg) begin // wait for clock low
            state_reg <= BIL_ST_WAIT;
          end
        end
        // RULE20: check crc before running, bypass word skips it
        BIL_ST_WAIT: state_reg <= (crc_word_reg == CRC_BYPASS || crc_word_reg == ~crc_reg) ?
                                  BIL_ST_RUN : BIL_ST_ERROR;
        BIL_ST_RUN, BIL_ST_ERROR, BIL_ST_EXTERN: state_reg <= state_reg;
        default: state_reg <= BIL_ST_RESET;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // serial clock and command shifter
  // ----------------------------------------------------------------
  logic spi_active;
  // a frame ends only with the clock low, so the last high phase runs out
  assign spi_active = (state_reg == BIL_ST_CMD) ||
                      (state_reg == BIL_ST_DATA && src_reg != BIL_SRC_OTP &&
                       (phase_reg != BIL_PH_DONE || sclk_reg));
  // RULE11: clock generated only while reading
  always_ff @(posedge mclk) begin
    if (reset || (clk_en && !spi_active)) begin
      div_cnt_reg <= 8'h00;
      sclk_reg <= 1'b0;
    end else if (clk_en) begin
      if (div_wrap) begin
        div_cnt_reg <= 8'h00;
        if (rise || fall) begin
          sclk_reg <= !sclk_reg;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end
  // RULE12: read command then zero address, single lane, msb first
  always_ff @(posedge mclk) begin
    if (reset || (clk_en && state_reg == BIL_ST_SELECT)) begin
      shift_reg <= {FLASH_READ_CMD, FLASH_START_ADDR};
      bit_cnt_reg <= 6'd0;
    end else if (clk_en && state_reg == BIL_ST_CMD && fall) begin
      shift_reg <= {shift_reg[30:0], 1'b0};
      bit_cnt_reg <= bit_cnt_reg + 6'd1;
    end
  end
  // RULE15: fixed pins; RULE16: no remapping path exists
  assign flash_select_pin = !spi_active;
  assign serial_clock_pin = sclk_reg;
  assign quad_data_out = {3'h0, shift_reg[31]};
  assign quad_data_oe = {3'h0, state_reg == BIL_ST_CMD};
  // ----------------------------------------------------------------
  // byte assembly
  // ----------------------------------------------------------------
  logic [7:0] bit_acc_reg;
  logic [2:0] bit_pos_reg;
  always_ff @(posedge mclk) begin
    if (reset || (clk_en && state_reg != BIL_ST_DATA)) begin
      nib_half_reg <= 1'b0;
      low_nib_reg <= 4'h0;
      bit_acc_reg <= 8'h00;
      bit_pos_reg <= 3'h0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      otp_pend_reg <= 1'b0;
      otp_addr <= OTP_START_ADDR;
    end else if (clk_en) begin
      byte_valid <= 1'b0;
      if (src_reg == BIL_SRC_OTP) begin
        // RULE17: otp read from address zero
        otp_pend_reg <= fifo_in_ready && phase_reg != BIL_PH_DONE && !otp_pend_reg;
        if (otp_pend_reg) begin
          byte_valid <= 1'b1;
          byte_data <= otp_data;
          otp_addr <= otp_addr + 16'h0001;
        end
      end else if (rise && src_reg == BIL_SRC_QSPI) begin
        // RULE14: low nibble first
        nib_half_reg <= !nib_half_reg;
        low_nib_reg <= qd_s2_reg;
        if (nib_half_reg) begin
          byte_valid <= 1'b1;
          byte_data <= {qd_s2_reg, low_nib_reg};
        end
      end else if (rise) begin
        // RULE18: single bit, lsb first on data lane 0
        bit_acc_reg <= {qd_s2_reg[0], bit_acc_reg[7:1]};
        bit_pos_reg <= bit_pos_reg + 3'h1;
        if (bit_pos_reg == 3'h7) begin
          byte_valid <= 1'b1;
          byte_data <= {qd_s2_reg[0], bit_acc_reg[7:1]};
        end
      end
    end
  end
  assign otp_rd = otp_pend_reg;
  // flushed on every select so tail bytes of a past boot never leak in
  bil_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk), .reset(reset || state_reg == BIL_ST_SELECT), .clk_en(clk_en),
    .in_valid(byte_valid), .in_ready(fifo_in_ready), .in_data(byte_data),
    .out_valid(fifo_out_valid), .out_ready(fifo_out_ready), .out_data(fifo_out_data)
  );
  // ----------------------------------------------------------------
  // image parser, crc and ram writes
  // ----------------------------------------------------------------
  assign fifo_out_ready = (phase_reg != BIL_PH_DONE);
  // RULE10: reflected crc per byte
  assign crc_next = bil_crc_byte(crc_reg, fifo_out_data);
  always_ff @(posedge mclk) begin
    if (reset || (clk_en && state_reg == BIL_ST_SELECT)) begin
      phase_reg <= BIL_PH_LEN;
      byte_idx_reg <= 2'h0;
      len_reg <= 32'h0;
      crc_word_reg <= 32'h0;
      crc_reg <= CRC_PRESET;
      prog_cnt_reg <= 32'h0;
      wr_addr_reg <= RAM_BASE_ADDR;
      ram_we <= 1'b0;
      ram_addr <= RAM_BASE_ADDR;
      ram_wdata <= 8'h00;
    end else if (clk_en) begin
      ram_we <= 1'b0;
      if (fifo_out_valid && fifo_out_ready) begin
        byte_idx_reg <= byte_idx_reg + 2'h1;
        case (phase_reg)
          BIL_PH_LEN: begin
            // RULE7: length lsb first; RULE9: length in crc
            len_reg <= {fifo_out_data, len_reg[31:8]};
            crc_reg <= crc_next;
            if (byte_idx_reg == 2'h3) begin
              phase_reg <= ({fifo_out_data, len_reg[31:8]} == 32'h0) ? BIL_PH_CRC : BIL_PH_PROG;
              prog_cnt_reg <= {fifo_out_data[5:0], len_reg[31:8], 2'h0};
            end
          end
          BIL_PH_PROG: begin
            // RULE6: four bytes per word; RULE8: ram from lowest address
            crc_reg <= crc_next;
            ram_we <= 1'b1;
            ram_addr <= wr_addr_reg;
            ram_wdata <= fifo_out_data;
            wr_addr_reg <= wr_addr_reg + 16'h0001;
            prog_cnt_reg <= prog_cnt_reg - 32'h1;
            if (prog_cnt_reg == 32'h1) begin
              phase_reg <= BIL_PH_CRC;
            end
          end
          BIL_PH_CRC: begin
            // RULE7: crc word lsb first, kept out of the crc
            crc_word_reg <= {fifo_out_data, crc_word_reg[31:8]};
            if (byte_idx_reg == 2'h3) begin
              phase_reg <= BIL_PH_DONE;
            end
          end
          default: phase_reg <= BIL_PH_DONE;
        endcase
      end
    end
  end
  // RULE8: execution starts at ram base
  assign run_addr = RAM_BASE_ADDR;
  assign run_start = (state_reg == BIL_ST_RUN);
  assign boot_done = (state_reg == BIL_ST_RUN) || (state_reg == BIL_ST_EXTERN);
  assign boot_error = (state_reg == BIL_ST_ERROR);
endmodule : bil_loader
`default_nettype wire

// File: verif/bil_loader_properties.sv
// concurrent checks on the boot image loader ports, bound to bil_loader
// assumes one clock domain (mclk) with synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module bil_loader_properties
  import bil_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic rst_n_pin,
  input wire logic [31:0] security_reg,
  input wire logic pin_pulldown_en,
  input wire logic flash_select_pin,
  input wire logic serial_clock_pin,
  input wire logic [3:0] quad_data_oe,
  input wire logic otp_rd,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [2:0] tile0_source,
  input wire logic [2:0] tile1_source,
  input wire logic [7:0] links_enabled,
  input wire logic links_five_wire,
  input wire logic run_start,
  input wire logic [15:0] run_addr,
  input wire logic boot_done,
  input wire logic boot_error
);
  logic [15:0] phase_cnt;
  logic wr_seen;
  logic [15:0] wr_last;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // cycles since the pull-down dropped, saturating so it never wraps
  always_ff @(posedge mclk) begin
    if (reset || pin_pulldown_en) phase_cnt <= 16'h0000;
    else if (phase_cnt != 16'hffff) phase_cnt <= phase_cnt + 16'h0001;
  end
  // first ram write of a boot versus later ones
  always_ff @(posedge mclk) begin
    if (reset || pin_pulldown_en) wr_seen <= 1'b0;
    else if (ram_we) wr_seen <= 1'b1;
  end
  // address of the previous ram write
  always_ff @(posedge mclk) begin
    if (ram_we) wr_last <= ram_addr;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pulldown_held: assert property (!rst_n_pin [*3] |-> pin_pulldown_en)
    else $error("pull-down not enabled while chip reset held");
  a_reset_phase: assert property ((!flash_select_pin || ram_we || otp_rd) |->
    phase_cnt >= 16'(RESET_PHASE_CYCLES)) else $error("boot began inside reset phase");
  a_secure_no_flash: assert property (security_reg[SECURE_BOOT_BIT] |-> flash_select_pin)
    else $error("flash selected while secure boot set");
  a_flash_src_only: assert property (!flash_select_pin |->
    tile0_source inside {BIL_SRC_QSPI, BIL_SRC_SPI}) else $error("flash used by wrong source");
  a_links_chan_boot: assert property (links_enabled != 8'h00 |->
    tile0_source == BIL_SRC_CHAN && tile1_source == BIL_SRC_CHAN) else $error("links without chan");
  a_five_wire_map: assert property (links_enabled != 8'h00 |->
    links_five_wire == (links_enabled != 8'h01)) else $error("wire mode does not match links");
  a_ram_ascending: assert property (ram_we |->
    ram_addr == (wr_seen ? wr_last + 16'h0001 : RAM_BASE_ADDR)) else $error("ram write out of order");
  a_run_base_addr: assert property (run_start |-> run_addr == RAM_BASE_ADDR && boot_done)
    else $error("program started away from ram base");
  a_error_blocks_run: assert property (boot_error |-> !run_start && !boot_done)
    else $error("program started after crc failure");
  a_clock_idle_low: assert property (flash_select_pin && $past(flash_select_pin, 2) |->
    !serial_clock_pin) else $error("serial clock not idle low");
  a_sclk_high_half: assert property ($rose(serial_clock_pin) && tile0_source == BIL_SRC_QSPI
    |-> serial_clock_pin [*4] ##1 !serial_clock_pin) else $error("quad clock high phase wrong");
  a_cmd_lane_zero: assert property (quad_data_oe != 4'h0 |->
    quad_data_oe == 4'h1 && !flash_select_pin) else $error("data lanes driven out of command");

  c_run: cover property ($rose(run_start));
  c_error: cover property ($rose(boot_error));
  c_otp: cover property ($rose(otp_rd));
endmodule : bil_loader_properties

bind bil_loader bil_loader_properties i_props (
  .mclk,
  .reset,
  .rst_n_pin,
  .security_reg,
  .pin_pulldown_en,
  .flash_select_pin,
  .serial_clock_pin,
  .quad_data_oe,
  .otp_rd,
  .ram_we,
  .ram_addr,
  .tile0_source,
  .tile1_source,
  .links_enabled,
  .links_five_wire,
  .run_start,
  .run_addr,
  .boot_done,
  .boot_error
);
`default_nettype wire

// File: verif/bil_flash_model.sv
// behavioural quad spi flash holding one boot image
// assumes mode 0 clocking; the bench merges its lanes with the loader's
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model (
  input wire logic serial_clock_pin,
  input wire logic flash_select_pin,
  input wire logic [3:0] quad_data_out,
  input wire logic [7:0] mem [0:63],
  output logic [3:0] flash_data,
  output logic [31:0] cmd_word
);
  int bits = 0;
  int nib = 0;

  initial flash_data = 4'h5;
  // new frame on select; lanes not left holding a stale value
  always @(negedge flash_select_pin) begin
    bits = 0;
    nib = 0;
    cmd_word = 32'h00000000;
  end
  always @(posedge flash_select_pin) flash_data <= ~flash_data;
  always @(posedge serial_clock_pin) begin
    if (!flash_select_pin && bits < 32) cmd_word = {cmd_word[30:0], quad_data_out[0]};
    if (!flash_select_pin) bits++;
  end
  // low nibble first, launched on falling clock
  always @(negedge serial_clock_pin) begin
    if (!flash_select_pin && bits >= 32) begin
      flash_data <= (nib % 2) ? mem[(nib / 2) % 64][7:4] : mem[(nib / 2) % 64][3:0];
      nib++;
    end else if (!flash_select_pin) begin
      flash_data <= ~flash_data;
    end
  end
endmodule : bil_flash_model
`default_nettype wire

// File: verif/bil_loader_tb.sv
// self-checking bench: strap decode, flash boots, crc cases, otp boot
// assumes the flash model file and the bound property checker
`timescale 1ns/1ps
`default_nettype none
module bil_loader_tb;
  import bil_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic rst_n_pin = 1'b0;
  logic [2:0] boot_strap_pins = 3'h0;
  logic [31:0] security_reg = 32'h00000000;
  logic pin_pulldown_en, flash_select_pin, serial_clock_pin, otp_rd, ram_we;
  logic links_five_wire, run_start, boot_done, boot_error;
  logic [3:0] quad_data_out, quad_data_oe, quad_data_in, flash_data;
  logic [15:0] otp_addr, ram_addr, run_addr;
  logic [7:0] otp_data, ram_wdata, links_enabled;
  logic [2:0] tile0_source, tile1_source;
  logic [31:0] cmd_word;
  logic [7:0] img [0:63];
  logic [7:0] lk [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hf0, 8'h66, 8'h0f};
  int rw [0:4] = '{3, 1, 2, 0, 2};
  int rm [0:4] = '{0, 1, 2, 0, 0};
  int err_total = 0;
  int samples_checked = 0;
  int wr_cnt = 0;

  always #50 mclk = ~mclk;
  // lane level: loader drives where enabled, flash elsewhere
  assign quad_data_in = (quad_data_oe & quad_data_out) | (~quad_data_oe & flash_data);
  assign otp_data = img[otp_addr[5:0]];

  bil_loader i_dut (
    .mclk(mclk), .reset(reset), .clk_en(clk_en), .rst_n_pin(rst_n_pin),
    .boot_strap_pins(boot_strap_pins), .security_reg(security_reg),
    .pin_pulldown_en(pin_pulldown_en), .flash_select_pin(flash_select_pin),
    .serial_clock_pin(serial_clock_pin), .quad_data_out(quad_data_out),
    .quad_data_oe(quad_data_oe), .quad_data_in(quad_data_in), .otp_addr(otp_addr),
    .otp_rd(otp_rd), .otp_data(otp_data), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .tile0_source(tile0_source), .tile1_source(tile1_source),
    .links_enabled(links_enabled), .links_five_wire(links_five_wire),
    .run_start(run_start), .run_addr(run_addr), .boot_done(boot_done),
    .boot_error(boot_error)
  );

  bil_flash_model i_flash (
    .serial_clock_pin(serial_clock_pin), .flash_select_pin(flash_select_pin),
    .quad_data_out(quad_data_out), .mem(img), .flash_data(flash_data), .cmd_word(cmd_word)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // reference crc, worked bit by bit over the first n image bytes
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h000000, img[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    end
    return ~c;
  endfunction : crc_of

  // image: length lsb first, program, crc good (0), bypass (1) or bad (2)
  task automatic build(input int words, input int mode);
    logic [31:0] crc;
    for (int i = 0; i < 4; i++) img[i] = 8'(words >> (8 * i));
    for (int i = 0; i < 4 * words; i++) img[4 + i] = 8'(i * 29 + 7);
    crc = crc_of(4 + 4 * words);
    if (mode == 1) crc = CRC_BYPASS;
    if (mode == 2) crc = crc ^ 32'h00000100;
    for (int i = 0; i < 4; i++) img[4 + 4 * words + i] = crc[8 * i +: 8];
    wr_cnt = 0;
  endtask : build

  // chip reset with the pull-down seen on and off
  task automatic start(input logic [2:0] straps, input logic secure);
    reset = 1'b1;
    rst_n_pin = 1'b0;
    boot_strap_pins = straps;
    security_reg = {26'h0000000, secure, 5'h00};
    tick(5);
    reset = 1'b0;
    tick(3);
    check(pin_pulldown_en, 1);
    rst_n_pin = 1'b1;
    tick(3);
    check(pin_pulldown_en, 0);
  endtask : start

  task automatic wait_done();
    int n;
    n = 0;
    while (boot_done !== 1'b1 && boot_error !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    if (n == 4000) begin
      check(0, 1);
      tally_and_finish();
    end
  endtask : wait_done

  // ----------------------------------------------------------------
  // monitor and sequence
  // ----------------------------------------------------------------
  // ram writes sampled mid-cycle, where they are settled
  always @(negedge mclk) begin
    if (ram_we === 1'b1) begin
      check(ram_addr, RAM_BASE_ADDR + 16'(wr_cnt));
      check(ram_wdata, img[4 + wr_cnt]);
      wr_cnt++;
    end
  end

  // strap table first, then flash boots with each crc case and one otp boot with a good crc
  initial begin
    for (int i = 0; i < 64; i++) img[i] = 8'h00;
    for (int s = 0; s < 8; s++) begin
      start(3'(s), 1'b0);
      tick(165);
      check(tile0_source, s > 3 ? 3 : (s > 1 ? 2 : s));
      check(tile1_source, s == 3 ? 2 : 3);
      check({links_five_wire, links_enabled}, {s > 4, lk[s]});
      check(boot_done, s > 1);
    end
    for (int r = 0; r < 5; r++) begin
      build(rw[r], rm[r]);
      start(3'h0, r == 4);
      wait_done();
      check(boot_error, rm[r] == 2);
      check(run_start, rm[r] != 2);
      check(wr_cnt, 4 * rw[r]);
      check(tile0_source, r == 4 ? 4 : 0);
      check(run_addr, 0);
      if (r < 4) check(cmd_word, 32'h03000000);
    end
    tally_and_finish();
  end
endmodule : bil_loader_tb
`default_nettype wire
